// ==== src/wcc_chopper.v ====
// Fixed-off-time PWM current chopper for two H-bridge windings
`timescale 1ns/10ps
`include "wcc_defines.vh"
module wcc_chopper #(
    parameter SENSE_W = 10,
    parameter BLANK_CYC = `WCC_BLANK_CYC
) (
    input wire clk_sys,
    input wire nrst,
    input wire [1:0] off_time_select,
    input wire [1:0] torque_select_lo,
    input wire [1:0] torque_select_hi,
    input wire [1:0] decay_select_lo,
    input wire [1:0] decay_select_hi,
    input wire [9:0] sine_code,
    input wire [1:0] current_rising,
    input wire [1:0] current_dir,
    input wire [2*SENSE_W-1:0] winding_sense_input,
    input wire [1:0] near_zero,
    output reg [7:0] bridge_gate_r,
    output reg [1:0] chop_trip_r,
    output reg outputs_off_r
);

    // ******************************************************
    // Tri-level sampling
    // ******************************************************
    // Pins arrive as {is_z, level}; folded to one code so the chopper sees clean values
    reg [1:0] decay_off_time_c_r;
    reg [1:0] tq_lo_r;
    reg [1:0] tq_hi_r;
    reg [1:0] dec_lo_r;
    reg [1:0] dec_hi_r;

    function [1:0] tri_dec;
        input [1:0] p;
        begin
            tri_dec = p[1] ? `WCC_TRI_Z : (p[0] ? `WCC_TRI_HI : `WCC_TRI_LO);
        end
    endfunction

    // Decode tri-level pins into two-bit codes
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            decay_off_time_c_r <= `WCC_TRI_LO;
            tq_lo_r <= `WCC_TRI_LO;
            tq_hi_r <= `WCC_TRI_LO;
            dec_lo_r <= `WCC_TRI_LO;
            dec_hi_r <= `WCC_TRI_LO;
        end else begin
            decay_off_time_c_r <= tri_dec(off_time_select);
            tq_lo_r <= tri_dec(torque_select_lo);
            tq_hi_r <= tri_dec(torque_select_hi);
            dec_lo_r <= tri_dec(decay_select_lo);
            dec_hi_r <= tri_dec(decay_select_hi);
        end
    end

    // ******************************************************
    // Shared settings
    // ******************************************************
    // Torque index 0..7 maps 100% down to 12.5%; 8 means off
    wire [3:0] tq_idx = {2'h0, tq_hi_r} * 4'h3 + {2'h0, tq_lo_r};
    wire tq_off = (tq_idx == 4'h8);
    // Eighths of full scale, shared by both bridges
    wire [3:0] tq_eighths = 4'h8 - tq_idx;

    // Integer copies so the counts can be cut to counter width on purpose
    localparam integer DECAY_OFF_TIME_LO_I = `WCC_DECAY_OFF_TIME_LO_CYC;
    localparam integer DECAY_OFF_TIME_Z_I = `WCC_DECAY_OFF_TIME_Z_CYC;
    localparam integer DECAY_OFF_TIME_HI_I = `WCC_DECAY_OFF_TIME_HI_CYC;
    localparam integer FS_MV_I = `WCC_FS_MV;

    reg [10:0] decay_off_time_cyc;
    // Off-time selection
    always @* begin
        case (decay_off_time_c_r)
            `WCC_TRI_Z: decay_off_time_cyc = DECAY_OFF_TIME_Z_I[10:0];
            `WCC_TRI_HI: decay_off_time_cyc = DECAY_OFF_TIME_HI_I[10:0];
            default: decay_off_time_cyc = DECAY_OFF_TIME_LO_I[10:0];
        endcase
    end

    // Sine-code weight in mV at full torque
    function [8:0] sine_mv;
        input [4:0] c;
        begin
            case (c)
                5'h00: sine_mv = 9'd0; 5'h01: sine_mv = 9'd25;
                5'h02: sine_mv = 9'd50; 5'h03: sine_mv = 9'd75;
                5'h04: sine_mv = 9'd100; 5'h05: sine_mv = 9'd120;
                5'h06: sine_mv = 9'd145; 5'h07: sine_mv = 9'd170;
                5'h08: sine_mv = 9'd190; 5'h09: sine_mv = 9'd215;
                5'h0a: sine_mv = 9'd235; 5'h0b: sine_mv = 9'd255;
                5'h0c: sine_mv = 9'd280; 5'h0d: sine_mv = 9'd300;
                5'h0e: sine_mv = 9'd315; 5'h0f: sine_mv = 9'd335;
                5'h10: sine_mv = 9'd355; 5'h11: sine_mv = 9'd370;
                5'h12: sine_mv = 9'd385; 5'h13: sine_mv = 9'd400;
                5'h14: sine_mv = 9'd415; 5'h15: sine_mv = 9'd430;
                5'h16: sine_mv = 9'd440; 5'h17: sine_mv = 9'd450;
                5'h18: sine_mv = 9'd460; 5'h19: sine_mv = 9'd470;
                5'h1a: sine_mv = 9'd480; 5'h1b: sine_mv = 9'd485;
                5'h1c: sine_mv = 9'd490; 5'h1d: sine_mv = 9'd495;
                default: sine_mv = FS_MV_I[8:0];
            endcase
        end
    endfunction

    // Fast-decay share in eighths of off-time; 9 marks one blanking interval
    function [3:0] fast_share;
        input [3:0] sel;
        input rising;
        begin
            case (sel)
                4'h0: fast_share = 4'h0;
                4'h1: fast_share = rising ? 4'h0 : 4'h2;
                4'h2: fast_share = rising ? 4'h0 : 4'h9;
                4'h3: fast_share = 4'h9;
                4'h4: fast_share = 4'h4;
                4'h5: fast_share = 4'h2;
                4'h6: fast_share = rising ? 4'h0 : 4'h4;
                4'h7: fast_share = rising ? 4'h0 : 4'h1;
                4'h8: fast_share = rising ? 4'h0 : 4'h8;
                default: fast_share = 4'h0;
            endcase
        end
    endfunction

    wire [3:0] dec_idx = {2'h0, dec_hi_r} * 4'h3 + {2'h0, dec_lo_r};

    // ******************************************************
    // Per-bridge chopping engine
    // ******************************************************
    localparam ST_DRIVE = 2'h0;
    localparam ST_FAST = 2'h1;
    localparam ST_SLOW = 2'h2;

    // Registered "outputs disabled" flag
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) outputs_off_r <= 1'b0;
        else outputs_off_r <= tq_off;
    end

    // Decode registers hold reset codes for one edge; bridges wait for real straps
    reg cfg_valid_r;
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) cfg_valid_r <= 1'b0;
        else cfg_valid_r <= 1'b1;
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_br
            reg [1:0] st_r;
            reg [1:0] st_nxt;
            reg [10:0] cnt_r;
            reg [10:0] cnt_nxt;
            reg [10:0] fast_len_r;
            reg [10:0] fast_nxt;
            reg [3:0] gate_nxt;
            // Trip level in mV scaled by eighths of torque
            wire [12:0] lvl_x8 = {4'h0, sine_mv(sine_code[5*g+4:5*g])} * {9'h0, tq_eighths};
            wire [SENSE_W-1:0] sense = winding_sense_input[SENSE_W*g+SENSE_W-1:SENSE_W*g];
            // Sense is in mV; compare sense*8 to level*8 to avoid division
            wire trip = ({3'h0, sense} << 3) >= lvl_x8;
            wire [3:0] share = fast_share(dec_idx, current_rising[g]);
            wire [13:0] share_cyc = {3'h0, decay_off_time_cyc} * {10'h0, share};
            wire [3:0] fwd = current_dir[g] ? `WCC_BR_REV : `WCC_BR_FWD;
            wire [3:0] rev = current_dir[g] ? `WCC_BR_FWD : `WCC_BR_REV;

            // Next state: drive until trip after blanking, then timed decay
            always @* begin
                st_nxt = st_r;
                cnt_nxt = cnt_r + 11'h1;
                fast_nxt = fast_len_r;
                gate_nxt = fwd;
                case (st_r)
                    ST_DRIVE: begin
                        // Blanking hides switching spikes and forces a minimum on-time
                        if (cnt_r >= BLANK_CYC[10:0] && trip) begin
                            cnt_nxt = 11'h0;
                            if (share == 4'h9)
                                fast_nxt = BLANK_CYC[10:0];
                            else
                                fast_nxt = share_cyc[13:3];
                            st_nxt = (share == 4'h0) ? ST_SLOW : ST_FAST;
                            gate_nxt = (share == 4'h0) ? `WCC_BR_SLOW : rev;
                        end
                    end
                    ST_FAST: begin
                        gate_nxt = near_zero[g] ? `WCC_BR_OFF : rev;
                        if (cnt_r + 11'h1 >= decay_off_time_cyc) begin
                            st_nxt = ST_DRIVE;
                            cnt_nxt = 11'h0;
                            gate_nxt = fwd;
                        end else if (cnt_r + 11'h1 >= fast_len_r) begin
                            st_nxt = ST_SLOW;
                            gate_nxt = `WCC_BR_SLOW;
                        end
                    end
                    ST_SLOW: begin
                        gate_nxt = `WCC_BR_SLOW;
                        if (cnt_r + 11'h1 >= decay_off_time_cyc) begin
                            st_nxt = ST_DRIVE;
                            cnt_nxt = 11'h0;
                            gate_nxt = fwd;
                        end
                    end
                    default: begin
                        st_nxt = ST_DRIVE;
                        cnt_nxt = 11'h0;
                    end
                endcase
                // Zero torque, or straps not yet decoded after reset, park the bridge
                if (tq_off || !cfg_valid_r) begin
                    st_nxt = ST_DRIVE;
                    cnt_nxt = 11'h0;
                    gate_nxt = `WCC_BR_OFF;
                end
                // Counter saturates during long drive phases
                if (st_r == ST_DRIVE && cnt_r == 11'h7ff)
                    cnt_nxt = cnt_r;
            end

            always @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    st_r <= ST_DRIVE;
                    cnt_r <= 11'h0;
                    fast_len_r <= 11'h0;
                    bridge_gate_r[4*g+3:4*g] <= `WCC_BR_OFF;
                    chop_trip_r[g] <= 1'b0;
                end else begin
                    st_r <= st_nxt;
                    cnt_r <= cnt_nxt;
                    fast_len_r <= fast_nxt;
                    bridge_gate_r[4*g+3:4*g] <= gate_nxt;
                    chop_trip_r[g] <= (st_r == ST_DRIVE) && (st_nxt != ST_DRIVE);
                end
            end
        end
    endgenerate
endmodule

// ==== src/wcc_defines.vh ====
// Constants for the winding current chopper
`ifndef WCC_DEFINES_VH
`define WCC_DEFINES_VH
// Tri-level decoded codes
`define WCC_TRI_LO 2'h0
`define WCC_TRI_Z 2'h1
`define WCC_TRI_HI 2'h2
// Clock rate and off-times
`define WCC_CLK_MHZ 50
`define WCC_DECAY_OFF_TIME_LO_US 20
`define WCC_DECAY_OFF_TIME_Z_US 10
`define WCC_DECAY_OFF_TIME_HI_US 30
`define WCC_DECAY_OFF_TIME_LO_CYC (`WCC_DECAY_OFF_TIME_LO_US * `WCC_CLK_MHZ)
`define WCC_DECAY_OFF_TIME_Z_CYC (`WCC_DECAY_OFF_TIME_Z_US * `WCC_CLK_MHZ)
`define WCC_DECAY_OFF_TIME_HI_CYC (`WCC_DECAY_OFF_TIME_HI_US * `WCC_CLK_MHZ)
// Default blanking interval in cycles
`define WCC_BLANK_CYC 75
// Full-scale trip level in mV
`define WCC_FS_MV 500
// Bridge drive encodings {hi_a,lo_a,hi_b,lo_b}
`define WCC_BR_OFF 4'h0
`define WCC_BR_FWD 4'h9
`define WCC_BR_REV 4'h6
`define WCC_BR_SLOW 4'h5
`endif

// ==== tb/wcc_chopper_assertions.sv ====
// Port-level checks for the winding current chopper
`timescale 1ns/10ps
module wcc_chopper_assertions #(parameter BLANK_CYC = 75) (
    input wire clk_sys,
    input wire nrst,
    input wire [1:0] torque_select_lo,
    input wire [1:0] torque_select_hi,
    input wire [1:0] near_zero,
    input wire [7:0] bridge_gate_r,
    input wire [1:0] chop_trip_r,
    input wire outputs_off_r
);
    // ****
    // Helper counters for bridge 0
    // ****
    reg [15:0] drive_cnt_r;
    reg [15:0] decay_cnt_r;
    reg in_decay_r;
    wire [3:0] nib0 = bridge_gate_r[3:0];
    wire parked = (nib0 == 4'h9) || outputs_off_r;
    // Counters restart at every drive so a stuck count fails at once
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            drive_cnt_r <= 16'h0000;
            decay_cnt_r <= 16'h0000;
            in_decay_r <= 1'b0;
        end else begin
            drive_cnt_r <= (nib0 == 4'h9) ? drive_cnt_r + 16'h0001 : 16'h0000;
            decay_cnt_r <= parked ? 16'h0000 : decay_cnt_r + 16'h0001;
            in_decay_r <= parked ? 1'b0 : (in_decay_r | chop_trip_r[0]);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_drive_end;
        $past(nib0) == 4'h9 && (nib0 == 4'h5 || nib0 == 4'h6);
    endsequence
    sequence s_drive_back;
        in_decay_r && $past(nib0) != 4'h9 && nib0 == 4'h9;
    endsequence
    property p_off_gates;
        outputs_off_r && $past(outputs_off_r) |-> bridge_gate_r == 8'h00;
    endproperty
    a_off_gates: assert property (p_off_gates) else $error("gates on at zero torque");
    property p_off_code;
        (torque_select_lo == 2'h1 && torque_select_hi == 2'h1) [*3] |-> ##[0:2] outputs_off_r;
    endproperty
    a_off_code: assert property (p_off_code) else $error("zero torque not flagged");
    property p_trip_gate;
        s_drive_end |-> ##[0:1] chop_trip_r[0];
    endproperty
    a_trip_gate: assert property (p_trip_gate) else $error("decay without trip pulse");
    property p_trip_pulse;
        chop_trip_r[1] |=> !chop_trip_r[1];
    endproperty
    a_trip_pulse: assert property (p_trip_pulse) else $error("trip pulse too long");
    property p_blank;
        s_drive_end |-> drive_cnt_r >= BLANK_CYC;
    endproperty
    a_blank: assert property (p_blank) else $error("trip inside blanking");
    property p_off_time;
        s_drive_back |-> decay_cnt_r inside {16'h01f4, 16'h03e8, 16'h05dc};
    endproperty
    a_off_time: assert property (p_off_time) else $error("off-time length wrong");
    property p_slow_hold;
        $past(nib0) == 4'h5 |-> nib0 != 4'h6;
    endproperty
    a_slow_hold: assert property (p_slow_hold) else $error("fast after slow");
    property p_fast_stop;
        nib0 == 4'h6 && near_zero[0] |=> nib0 != 4'h6;
    endproperty
    a_fast_stop: assert property (p_fast_stop) else $error("reverse drive at zero");
endmodule
bind wcc_chopper wcc_chopper_assertions #(.BLANK_CYC(BLANK_CYC)) wcc_chopper_assertions_inst (
    .clk_sys(clk_sys), .nrst(nrst), .torque_select_lo(torque_select_lo),
    .torque_select_hi(torque_select_hi), .near_zero(near_zero), .bridge_gate_r(bridge_gate_r),
    .chop_trip_r(chop_trip_r), .outputs_off_r(outputs_off_r));

// ==== tb/wcc_chopper_tb_top.sv ====
// Self-checking bench for the winding current chopper
`timescale 1ns/10ps
module wcc_chopper_tb_top;
    reg clk_sys = 1'b0;
    reg nrst = 1'b0;
    reg [1:0] off_time_select = 2'h0, torque_select_lo = 2'h0, torque_select_hi = 2'h0;
    reg [1:0] decay_select_lo = 2'h0, decay_select_hi = 2'h0, current_rising = 2'h0;
    reg [9:0] sine_code = 10'h000;
    reg [1:0] current_dir = 2'h0;
    reg [3:0] first_g;
    wire [19:0] winding_sense_input;
    wire [1:0] near_zero, chop_trip_r;
    wire [7:0] bridge_gate_r;
    wire outputs_off_r;
    integer errors = 0, n_checks = 0, fast_n, total_n, t, d;
    // Mixed share in eighths per strap, 9 meaning one blanking interval
    localparam [35:0] DEC_TBL = 36'h814249920;
    localparam [35:0] RISE_TBL = 36'h000249000;
    localparam [15:0] TQ_LIST = 16'h1540;
    always #10 clk_sys = ~clk_sys;
    wcc_chopper #(.SENSE_W(10), .BLANK_CYC(75)) wcc_chopper_inst (
        .clk_sys(clk_sys), .nrst(nrst), .off_time_select(off_time_select),
        .torque_select_lo(torque_select_lo), .torque_select_hi(torque_select_hi),
        .decay_select_lo(decay_select_lo), .decay_select_hi(decay_select_hi),
        .sine_code(sine_code), .current_rising(current_rising), .current_dir(current_dir),
        .winding_sense_input(winding_sense_input), .near_zero(near_zero),
        .bridge_gate_r(bridge_gate_r), .chop_trip_r(chop_trip_r), .outputs_off_r(outputs_off_r));
    wcc_winding_model #(.SENSE_W(10)) wcc_winding_model_inst (.clk_sys(clk_sys), .nrst(nrst),
        .bridge_gate_r(bridge_gate_r), .winding_sense_input(winding_sense_input),
        .near_zero(near_zero), .current_dir(current_dir));
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task complete_run;
        begin
            if (errors == 0 && n_checks > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    function [1:0] tri3(input integer v);
        tri3 = (v == 0) ? 2'h0 : ((v == 1) ? 2'h2 : 2'h1);
    endfunction
    // Straps change only under reset, as a host would set them
    task write_pins(input integer decay_off_time, input integer tq, input integer dec, input [9:0] sc,
                    input integer rise);
        begin
            nrst = 1'b0;
            off_time_select = tri3(decay_off_time);
            torque_select_hi = tri3(tq / 3);
            torque_select_lo = tri3(tq % 3);
            decay_select_hi = tri3(dec / 3);
            decay_select_lo = tri3(dec % 3);
            sine_code = sc;
            current_rising = {2{rise[0]}};
            repeat (16) @(negedge clk_sys);
            nrst = 1'b1;
        end
    endtask
    // One PWM cycle of bridge b; lim is eight times the trip level, 0 skips it
    task automatic read_cycle(input integer b, input integer lim);
        integer k, sp;
        reg [3:0] drv;
        begin
            // Forward drive pattern follows the bridge's polarity strap
            drv = current_dir[b] ? 4'h6 : 4'h9;
            for (k = 0; k < 4000 && bridge_gate_r[4*b +: 4] !== drv; k = k + 1)
                @(negedge clk_sys);
            for (sp = 0; k < 4000 && bridge_gate_r[4*b +: 4] === drv; k = k + 1) begin
                sp = winding_sense_input[10*b +: 10];
                @(negedge clk_sys);
            end
            first_g = bridge_gate_r[4*b +: 4];
            total_n = 0;
            fast_n = 0;
            for (k = k; k < 4000 && bridge_gate_r[4*b +: 4] !== drv; k = k + 1) begin
                total_n = total_n + 1;
                fast_n = fast_n + (bridge_gate_r[4*b +: 4] !== 4'h5);
                @(negedge clk_sys);
            end
            if (k >= 4000) begin
                errors = errors + 1;
                complete_run;
            end
            if (lim > 0) check(sp * 8 >= lim && sp * 8 - 8 < lim, 1);
        end
    endtask
    initial begin
        // Trip level for four torque straps, both windings at once
        for (t = 0; t < 4; t = t + 1) begin
            d = TQ_LIST[4*t +: 4];
            write_pins(1, d, 0, (t % 2) ? 10'h32d : 10'h3f3, 0);
            fork
                read_cycle(0, ((t % 2) ? 300 : 400) * (8 - d));
                read_cycle(1, ((t % 2) ? 470 : 500) * (8 - d));
            join
        end
        // Every off-time strap with slow decay
        for (t = 0; t < 3; t = t + 1) begin
            write_pins(t, 0, 0, 10'h004, 0);
            read_cycle(0, 0);
            check(total_n, (t == 0) ? 1000 : ((t == 1) ? 500 : 1500));
            check(first_g, 4'h5);
        end
        // Every decay strap for falling, then rising current
        for (t = 0; t < 18; t = t + 1) begin
            d = (t >= 9) ? RISE_TBL[4*(t-9) +: 4] : DEC_TBL[4*t +: 4];
            write_pins(0, 0, t % 9, 10'h004, t >= 9);
            read_cycle(0, 0);
            check(fast_n, (d == 9) ? 75 : 125 * d);
            check(first_g, (d == 0) ? 4'h5 : 4'h6);
            check(total_n, 1000);
        end
        // Reversed polarity on bridge 1: fast decay must swap to the other diagonal
        current_dir = 2'h2;
        write_pins(0, 0, 8, 10'h084, 0);
        read_cycle(1, 800);
        check(first_g, 4'h9);
        check(fast_n, 1000);
        check(total_n, 1000);
        // Zero-torque strap parks both bridges, from the first edge after reset
        write_pins(1, 8, 0, 10'h3ff, 0);
        for (t = 0; t < 4; t = t + 1) begin
            @(negedge clk_sys);
            check(bridge_gate_r, 8'h00);
        end
        check(outputs_off_r, 1);
        complete_run;
    end
endmodule

// ==== tb/wcc_winding_model.sv ====
// Behavioural windings and sense resistors for both bridges
`timescale 1ns/10ps
module wcc_winding_model #(parameter SENSE_W = 10) (
    input wire clk_sys,
    input wire nrst,
    input wire [1:0] current_dir,
    input wire [7:0] bridge_gate_r,
    output wire [2*SENSE_W-1:0] winding_sense_input,
    output wire [1:0] near_zero
);
    genvar b;
    generate
        for (b = 0; b < 2; b = b + 1) begin : g_wind
            reg [SENSE_W-1:0] amp_r;
            wire [3:0] nib = bridge_gate_r[4*b+3:4*b];
            // Polarity decides which bridge pattern builds current and which reverses it
            wire [3:0] up = current_dir[b] ? 4'h6 : 4'h9;
            wire [3:0] dn = current_dir[b] ? 4'h9 : 4'h6;
            // Drive ramps 1 mV a cycle; fast decay falls twice as fast as slow
            always @(posedge clk_sys or negedge nrst) begin
                if (!nrst) amp_r <= 0;
                else if (nib == up) amp_r <= amp_r + 1;
                else if (nib == dn) amp_r <= (amp_r > 2) ? amp_r - 2 : 0;
                else if (nib == 4'h5 && amp_r != 0) amp_r <= amp_r - 1;
            end
            assign winding_sense_input[SENSE_W*b +: SENSE_W] = amp_r;
            assign near_zero[b] = (amp_r < 4);
        end
    endgenerate
endmodule
